// File: tilc_pkg.sv
package tilc_pkg;
    localparam int          CODE_W        = 21;
    localparam int          LUT_AW        = 8;
    localparam int          LUT_DEPTH     = 256;
    localparam int          LUT_DW        = 8;
    localparam int          FIFO_DEPTH    = 8;
    localparam int          CLK_PERIOD_NS = 20;
    localparam int          TCLOCK_NS     = 25;
    localparam logic [1:0]  RES_800PS     = 2'h0;
    localparam logic [1:0]  RES_200PS     = 2'h1;
    localparam logic [1:0]  RES_100PS     = 2'h2;
    localparam logic [7:0]  IDX_MASK      = 8'hFF;
    localparam int          CTRL_EN_BIT   = 5;
    localparam logic [15:0] CTRL_RESET    = 16'h0020;
    localparam logic [7:0]  LUT_LAST      = 8'hFF;
endpackage : tilc_pkg

// File: tilc_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module tilc_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_in,    // clock
    input  wire logic             rst_n_in,  // synced reset, active low
    input  wire logic [WIDTH-1:0] wdata_in,  // write data
    input  wire logic             wvalid_in, // write valid
    output logic                  wready_out, // not full
    output logic      [WIDTH-1:0] rdata_out, // head data
    output logic                  rvalid_out, // not empty
    input  wire logic             rready_in  // read accept
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wptr_q;
    logic [AW:0]      rptr_q;
    wire              do_wr = wvalid_in && wready_out;
    wire              do_rd = rvalid_out && rready_in;
    assign wready_out = (wptr_q - rptr_q) != (AW+1)'(DEPTH);
    assign rvalid_out = wptr_q != rptr_q;
    assign rdata_out  = mem[rptr_q[AW-1:0]];
    always_ff @(posedge clk_in) begin
        if (do_wr) begin
            mem[wptr_q[AW-1:0]] <= wdata_in;
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else begin
            wptr_q <= wptr_q + (AW+1)'(do_wr);
            rptr_q <= rptr_q + (AW+1)'(do_rd);
        end
    end
endmodule : tilc_fifo
`default_nettype wire

// File: tilc_corrector.sv
`timescale 1ns/10ps
`default_nettype none
module tilc_corrector (
    input  wire logic                                    clk_in,          // 50 MHz clock
    input  wire logic                                    resetn_in,       // async reset, low
    input  wire logic [1:0]                              res_sel_in,      // bin size select
    input  wire logic                                    ctrl_wr_in,      // control write strobe
    input  wire logic [15:0]                             ctrl_wdata_in,   // control write data
    input  wire logic                                    flash_valid_in,  // flash entry valid
    input  wire logic [tilc_pkg::LUT_DW-1:0]             flash_data_in,   // flash entry, signed
    output logic                                         flash_ready_out, // loader accepts entry
    input  wire logic [tilc_pkg::CODE_W-1:0]             code_in,         // measured code
    input  wire logic                                    code_valid_in,   // code valid
    output logic                                         code_ready_out,  // code accepted
    output logic [tilc_pkg::CODE_W-1:0]                  code_out,        // corrected code
    output logic                                         code_valid_out,  // output valid
    input  wire logic                                    code_ready_in,   // downstream ready
    output logic                                         lut_loaded_out,  // table complete
    output logic                                         comp_en_out      // enable bit state
);
    typedef enum logic [2:0] {
        S_LOAD = 3'b001,
        S_RUN  = 3'b010,
        S_IDLE = 3'b100
    } tilc_state_e;

    logic                                rst_s1_q;
    logic                                rst_n;
    logic signed [tilc_pkg::LUT_DW-1:0]  lut [tilc_pkg::LUT_DEPTH];
    logic [tilc_pkg::LUT_AW-1:0]         ld_idx_q;
    tilc_state_e                         state_q;
    tilc_state_e                         state_d;
    logic [15:0]                         ctrl_q;
    logic [tilc_pkg::CODE_W-1:0]         s1_code_q;
    logic signed [tilc_pkg::LUT_DW-1:0]  s1_lut_q;
    logic                                s1_apply_q;
    logic                                s1_valid_q;
    logic [tilc_pkg::CODE_W-1:0]         s2_code_q;
    logic                                s2_valid_q;
    logic                                lut_loaded_q;
    logic                                fifo_wready;
    logic [tilc_pkg::CODE_W-1:0]         fifo_rdata;
    logic                                fifo_rvalid;
    logic                                ctrl_en_q;
    logic                                flash_rdy_q;
    logic [tilc_pkg::LUT_AW:0]           load_cyc_q;

    // reset release through two flops; assert stays asynchronous
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // table loader: 256 entries streamed from flash in index order
    wire load_fire = (state_q == S_LOAD) && flash_valid_in;
    wire load_last = load_fire && (ld_idx_q == tilc_pkg::LUT_LAST);
    // ready comes from a flop that tracks state_q exactly, so no extra handshake delay
    assign flash_ready_out = flash_rdy_q;
    // cycles spent loading, saturating; only the checks below read it
    wire [tilc_pkg::LUT_AW:0] load_cyc_d = (state_q == S_LOAD) ?
        load_cyc_q + {{tilc_pkg::LUT_AW{1'b0}}, !load_cyc_q[tilc_pkg::LUT_AW]} : '0;

    always_comb begin
        case (state_q)
            S_LOAD:  state_d = load_last ? S_RUN : S_LOAD;
            S_RUN:   state_d = S_RUN;
            S_IDLE:  state_d = S_LOAD;
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (load_fire) begin
            lut[ld_idx_q] <= flash_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= S_IDLE;
            ld_idx_q    <= '0;
            flash_rdy_q <= 1'b0;
            load_cyc_q  <= '0;
        end else begin
            state_q     <= state_d;
            ld_idx_q    <= ld_idx_q + {{(tilc_pkg::LUT_AW - 1){1'b0}}, load_fire};
            flash_rdy_q <= (state_d == S_LOAD);
            load_cyc_q  <= load_cyc_d;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= tilc_pkg::CTRL_RESET;
        end else if (ctrl_wr_in) begin
            ctrl_q <= ctrl_wdata_in;
        end
    end

    // correction decision; 800 ps bins are already linear enough
    wire comp_en    = ctrl_q[tilc_pkg::CTRL_EN_BIT];
    wire res_fine   = (res_sel_in == tilc_pkg::RES_200PS) ||
                      (res_sel_in == tilc_pkg::RES_100PS);
    wire apply_corr = comp_en && res_fine;
    // low byte is the bin inside one clock period, so the index wraps itself
    wire [tilc_pkg::LUT_AW-1:0] lut_idx =
        code_in[tilc_pkg::LUT_AW-1:0] & tilc_pkg::IDX_MASK;

    // pipeline advances only when the fifo can take what stage 2 holds
    wire pipe_go = (state_q == S_RUN) && (fifo_wready || !s2_valid_q);
    assign code_ready_out = pipe_go;
    wire take = pipe_go && code_valid_in;

    wire signed [tilc_pkg::CODE_W:0] s1_ext = {1'b0, s1_code_q};
    wire signed [tilc_pkg::CODE_W:0] lut_ext =
        {{(tilc_pkg::CODE_W + 1 - tilc_pkg::LUT_DW){s1_lut_q[tilc_pkg::LUT_DW-1]}}, s1_lut_q};
    wire signed [tilc_pkg::CODE_W:0] diff = s1_ext - lut_ext;
    // bypass goes through the same two stages, only the subtrahend is dropped
    wire [tilc_pkg::CODE_W-1:0] s2_next =
        s1_apply_q ? diff[tilc_pkg::CODE_W-1:0] : s1_code_q;

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            s1_code_q  <= '0;
            s1_lut_q   <= '0;
            s1_apply_q <= 1'b0;
            s1_valid_q <= 1'b0;
            s2_code_q  <= '0;
            s2_valid_q <= 1'b0;
        end else if (pipe_go) begin
            s1_code_q  <= code_in;
            s1_lut_q   <= lut[lut_idx];
            s1_apply_q <= apply_corr;
            s1_valid_q <= take;
            s2_code_q  <= s2_next;
            s2_valid_q <= s1_valid_q;
        end else begin
            s2_valid_q <= s2_valid_q && !fifo_wready;
        end
    end

    // output register; refills only when empty or being consumed
    // declared ahead of the fifo, whose read side it drives
    wire out_take = fifo_rvalid && (!code_valid_out || code_ready_in);

    tilc_fifo #(
        .WIDTH (tilc_pkg::CODE_W),
        .DEPTH (tilc_pkg::FIFO_DEPTH)
    ) tilc_fifo_i (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n),
        .wdata_in   (s2_code_q),
        .wvalid_in  (s2_valid_q),
        .wready_out (fifo_wready),
        .rdata_out  (fifo_rdata),
        .rvalid_out (fifo_rvalid),
        .rready_in  (out_take)
    );

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            code_out       <= '0;
            code_valid_out <= 1'b0;
            lut_loaded_q   <= 1'b0;
            ctrl_en_q      <= 1'b1;
        end else begin
            if (out_take) begin
                code_out <= fifo_rdata;
            end
            if (out_take) begin
                code_valid_out <= 1'b1;
            end else if (code_ready_in) begin
                code_valid_out <= 1'b0;
            end
            lut_loaded_q <= (state_d == S_RUN);
            ctrl_en_q    <= comp_en;
        end
    end
    assign lut_loaded_out = lut_loaded_q;
    assign comp_en_out    = ctrl_en_q;

    // checks
    sequence load_done_s;
        (state_q == S_LOAD) ##1 (state_q == S_RUN);
    endsequence

    a_pass_through: assert property (@(posedge clk_in) disable iff (!rst_n)
        pipe_go && s1_valid_q && !s1_apply_q |=> s2_code_q == $past(s1_code_q))
        else $error("bypass code altered");
    a_corr_value: assert property (@(posedge clk_in) disable iff (!rst_n)
        pipe_go && s1_valid_q && s1_apply_q |=> s2_code_q == $past(diff[tilc_pkg::CODE_W-1:0]))
        else $error("corrected code wrong");
    a_coarse_res_bypass: assert property (@(posedge clk_in) disable iff (!rst_n)
        take && (res_sel_in == tilc_pkg::RES_800PS) |=> !s1_apply_q)
        else $error("correction applied at coarse bins");
    a_enable_gate: assert property (@(posedge clk_in) disable iff (!rst_n)
        take && !ctrl_q[tilc_pkg::CTRL_EN_BIT] |=> !s1_apply_q)
        else $error("correction applied while disabled");
    a_enable_reset: assert property (@(posedge clk_in)
        $rose(rst_n) |-> ctrl_q[tilc_pkg::CTRL_EN_BIT])
        else $error("enable bit not set after reset");
    a_no_data_unloaded: assert property (@(posedge clk_in) disable iff (!rst_n)
        (state_q != S_RUN) |-> !code_ready_out)
        else $error("code taken before table loaded");
    a_load_complete: assert property (@(posedge clk_in) disable iff (!rst_n)
        load_done_s |-> $past(ld_idx_q) == tilc_pkg::LUT_LAST)
        else $error("table load ended short");
    a_stage_latency: assert property (@(posedge clk_in) disable iff (!rst_n)
        take ##1 pipe_go |=> s2_valid_q)
        else $error("pipeline latency differs");

    // table load: starts at entry 0, steps by one, never shorter than the table
    sequence load_start_s;
        (state_q == S_IDLE) ##1 (state_q == S_LOAD);
    endsequence

    sequence load_step_s;
        load_fire && !load_last;
    endsequence

    a_reset_idle: assert property (@(posedge clk_in)
        $rose(rst_n) |-> (state_q == S_IDLE) && !code_valid_out && !flash_ready_out)
        else $error("outputs active at reset release");
    a_load_first_idx: assert property (@(posedge clk_in) disable iff (!rst_n)
        load_start_s |-> ld_idx_q == 8'h00)
        else $error("table load does not start at entry 0");
    a_load_index_step: assert property (@(posedge clk_in) disable iff (!rst_n)
        load_step_s |=> ld_idx_q == $past(ld_idx_q) + 8'h01)
        else $error("table index skipped an entry");
    a_load_duration: assert property (@(posedge clk_in) disable iff (!rst_n)
        load_done_s |-> $past(load_cyc_q) >= {1'b0, tilc_pkg::LUT_LAST})
        else $error("table load too short");
    a_lut_write: assert property (@(posedge clk_in) disable iff (!rst_n)
        load_fire |=> lut[$past(ld_idx_q)] == $past(flash_data_in))
        else $error("table entry not stored");
    a_flash_closed: assert property (@(posedge clk_in) disable iff (!rst_n)
        (state_q != S_LOAD) |-> !flash_ready_out)
        else $error("loader ready outside load");
    a_loaded_flag: assert property (@(posedge clk_in) disable iff (!rst_n)
        lut_loaded_out == (state_q == S_RUN))
        else $error("loaded flag disagrees with state");
    a_run_sticky: assert property (@(posedge clk_in) disable iff (!rst_n)
        (state_q == S_RUN) |=> (state_q == S_RUN))
        else $error("left run state without reset");

    // correction path: what stage 1 captures for each accepted code
    a_stage1_capture: assert property (@(posedge clk_in) disable iff (!rst_n)
        take |=> s1_valid_q && s1_code_q == $past(code_in))
        else $error("stage 1 missed an accepted code");
    // index must come from the low byte alone, whatever the coarse bits hold
    a_lut_index: assert property (@(posedge clk_in) disable iff (!rst_n)
        take |=> s1_lut_q == lut[$past(code_in[tilc_pkg::LUT_AW-1:0])])
        else $error("wrong table entry selected");
    a_fine_res_apply: assert property (@(posedge clk_in) disable iff (!rst_n)
        take && ctrl_q[tilc_pkg::CTRL_EN_BIT] &&
        ((res_sel_in == tilc_pkg::RES_200PS) || (res_sel_in == tilc_pkg::RES_100PS))
        |=> s1_apply_q)
        else $error("correction missing at fine bins");
    a_spare_res_bypass: assert property (@(posedge clk_in) disable iff (!rst_n)
        take && (res_sel_in == 2'h3) |=> !s1_apply_q)
        else $error("correction applied at spare bin code");
    // enable reaches the port two edges after the write strobe
    a_enable_copy: assert property (@(posedge clk_in) disable iff (!rst_n)
        ctrl_wr_in |=> ##1 comp_en_out == $past(ctrl_wdata_in[tilc_pkg::CTRL_EN_BIT], 2))
        else $error("enable output does not follow write");
    a_ctrl_hold: assert property (@(posedge clk_in) disable iff (!rst_n)
        !ctrl_wr_in |=> $stable(ctrl_q))
        else $error("control changed without a write");

    // back-pressure: nothing moves or changes while its taker is not ready
    sequence out_stall_s;
        code_valid_out && !code_ready_in;
    endsequence

    a_fifo_accept: assert property (@(posedge clk_in) disable iff (!rst_n)
        s2_valid_q && !fifo_wready |=> s2_valid_q && $stable(s2_code_q))
        else $error("stage 2 lost a code while fifo full");
    a_out_hold: assert property (@(posedge clk_in) disable iff (!rst_n)
        out_stall_s |=> code_valid_out && $stable(code_out))
        else $error("output changed while stalled");
    a_out_load: assert property (@(posedge clk_in) disable iff (!rst_n)
        out_take |=> code_valid_out && code_out == $past(fifo_rdata))
        else $error("output register missed fifo head");
    // output drops only when taken and nothing waits behind it
    a_out_release: assert property (@(posedge clk_in) disable iff (!rst_n)
        code_valid_out && code_ready_in && !fifo_rvalid |=> !code_valid_out)
        else $error("output valid stuck after take");
endmodule : tilc_corrector
`default_nettype wire

// File: tilc_partner.sv
`timescale 1ns/10ps
`default_nettype none
module tilc_partner (
    input  wire logic       clk_in,       // clock
    input  wire logic       rst_n_in,     // reset, active low
    input  wire logic       stall_in,     // hold off the readout side
    input  wire logic       fl_ready_in,  // loader accepts entry
    output logic            fl_valid_out, // entry valid
    output logic [7:0]      fl_data_out,  // table entry
    output logic            rd_ready_out  // readout ready
);
    logic [8:0] idx_q;
    logic [7:0] ent;
    // signed rounded error counts, an arbitrary but index-unique pattern
    assign ent          = 8'(idx_q * 37 + 11);
    assign fl_valid_out = !idx_q[8] && rst_n_in;
    // a released data line must not keep showing the last entry
    assign fl_data_out  = fl_valid_out ? ent : ~ent;
    assign rd_ready_out = !stall_in;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) idx_q <= 9'h000;
        else if (fl_valid_out && fl_ready_in) idx_q <= idx_q + 9'h001;
    end
endmodule : tilc_partner
`default_nettype wire

// File: tilc_inl_lut_corrector_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tilc_inl_lut_corrector_tb;
    logic        clk, rstn, wr, cv, cvo, crdy, rrdy, stall, fv, fr, ld, en;
    logic [1:0]  res;
    logic [15:0] wd;
    logic [7:0]  fd;
    logic [20:0] code, co;
    logic [20:0] q[$];
    int          fail_count, cmp_count;
    localparam logic [20:0] CODES [5] = '{21'h0_0000, 21'h0_00ff, 21'h12_34ff,
                                          21'h1f_ff80, 21'h0_0100};
    tilc_corrector tilc_corrector_i (.clk_in(clk), .resetn_in(rstn), .res_sel_in(res),
        .ctrl_wr_in(wr), .ctrl_wdata_in(wd), .flash_valid_in(fv), .flash_data_in(fd),
        .flash_ready_out(fr), .code_in(code), .code_valid_in(cv), .code_ready_out(crdy),
        .code_out(co), .code_valid_out(cvo), .code_ready_in(rrdy), .lut_loaded_out(ld),
        .comp_en_out(en));
    tilc_partner tilc_partner_i (.clk_in(clk), .rst_n_in(rstn), .stall_in(stall),
        .fl_ready_in(fr), .fl_valid_out(fv), .fl_data_out(fd), .rd_ready_out(rrdy));
    always #10 clk = ~clk;
    function automatic logic [20:0] fix(logic [20:0] c, logic on);
        logic [7:0] b;
        b = 8'(c[7:0] * 37 + 11);
        fix = on ? c - {{13{b[7]}}, b} : c;
    endfunction : fix
    task automatic chk(logic [31:0] a, logic [31:0] b);
        cmp_count++;
        if (a !== b) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, a, b);
        end
    endtask : chk
    task automatic stop_test;
        if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task automatic push(logic [20:0] c, logic [20:0] e, output bit ok);
        int n;
        n = 0;
        @(negedge clk);
        cv = 1'b1;
        code = c;
        while (!crdy && n < 20) begin
            @(negedge clk);
            n++;
        end
        ok = crdy;
        if (ok) begin
            q.push_back(e);
            @(negedge clk);
        end
        cv = 1'b0;
    endtask : push
    task automatic drain;
        int n;
        n = 0;
        while (q.size() != 0 && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk(q.size(), 0);
    endtask : drain
    task automatic wctl(logic [15:0] v);
        @(negedge clk);
        wr = 1'b1;
        wd = v;
        @(negedge clk);
        wr = 1'b0;
        @(negedge clk);
        chk(en, v[5]);
    endtask : wctl
    always @(posedge clk) begin
        if (rstn && cvo && rrdy) begin
            if (q.size() == 0) chk(1, 0);
            else chk(co, q.pop_front());
        end
    end
    task automatic t_load;
        int n;
        n = 0;
        chk(en, 1);
        chk(crdy, 0);
        chk(ld, 0);
        repeat (4) @(negedge clk);
        chk(fr, 1);
        while (!ld && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk(ld, 1);
        chk(fr, 0);
    endtask : t_load
    task automatic t_codes;
        bit ok;
        for (int r = 0; r < 4; r++) begin
            res = 2'(r);
            foreach (CODES[i]) push(CODES[i], fix(CODES[i], r == 1 || r == 2), ok);
            drain();
        end
    endtask : t_codes
    task automatic t_ctrl;
        bit ok;
        res = tilc_pkg::RES_100PS;
        wctl(16'h0000);
        foreach (CODES[i]) push(CODES[i], CODES[i], ok);
        drain();
        wctl(tilc_pkg::CTRL_RESET);
        push(21'h12_34ff, fix(21'h12_34ff, 1'b1), ok);
        drain();
    endtask : t_ctrl
    task automatic t_fill;
        int n;
        bit ok;
        n = 0;
        ok = 1;
        stall = 1'b1;
        while (ok && n < 30) begin
            push(21'(n * 21'h0_0101), fix(21'(n * 21'h0_0101), 1'b1), ok);
            if (ok) n++;
        end
        chk(n >= tilc_pkg::FIFO_DEPTH, 1);
        chk(cvo, 1);
        stall = 1'b0;
        drain();
    endtask : t_fill
    task automatic lat(logic [1:0] r, output int n);
        bit ok;
        res = r;
        n = 0;
        push(21'h0_0a7f, fix(21'h0_0a7f, r != tilc_pkg::RES_800PS), ok);
        while (!cvo && n < 20) begin
            @(negedge clk);
            n++;
        end
        drain();
    endtask : lat
    task automatic t_reset;
        bit ok;
        wctl(16'h0000);
        @(negedge clk);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        t_load();
        res = tilc_pkg::RES_200PS;
        push(21'h0_0a7f, fix(21'h0_0a7f, 1'b1), ok);
        drain();
    endtask : t_reset
    initial begin
        int a, b;
        clk = 0; rstn = 0; wr = 0; wd = 16'h0000; cv = 0; code = 21'h0_0000;
        stall = 0; res = tilc_pkg::RES_200PS; fail_count = 0; cmp_count = 0;
        repeat (12) @(negedge clk);
        rstn = 1;
        t_load();
        t_codes();
        t_ctrl();
        t_fill();
        lat(tilc_pkg::RES_200PS, a);
        lat(tilc_pkg::RES_800PS, b);
        chk(a, b);
        t_reset();
        stop_test();
    end
    initial begin
        #100_000;
        fail_count++;
        stop_test();
    end
endmodule : tilc_inl_lut_corrector_tb
`default_nettype wire
